// >>> logic/amtc_monitor.sv
// One threshold monitor: compares a selected result against a limit.
// Assumes result posts are single-cycle valid pulses.
`timescale 1ns/100ps
`default_nettype none
module amtc_monitor import amtc_pkg::*; (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             srst,
    // Configuration and data
    input  wire amtc_mon_cfg_type cfg,
    input  wire amtc_result_type  result,
    input  wire logic [RES_W-1:0] cmp,
    // Event
    output logic                  irq
);
    logic irq_r;
    logic irq_nxt;
    logic hit;
    // ==========================================================
    // Compare on each new result in the watched register
    always_comb begin
        hit = cfg.dir ? (result.data > cmp) : (result.data < cmp);
        hit = hit && amtc_targets(cfg.sel, result.idx);
        hit = hit && cfg.en && result.valid;
        irq_nxt = hit && !srst;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
        end
    end
    assign irq = irq_r;
    // ==========================================================
    // Checks
    property p_mon_below;
        @(posedge pclk) disable iff (!presetn)
        cfg.en && !cfg.dir && result.valid && !srst && !cfg.sel[3]
        && result.idx == {1'b0, cfg.sel[2:0]} && result.data < cmp
        |=> irq;
    endproperty
    a_mon_below: assert property (p_mon_below)
        else $error("monitor missed a below-limit result");
    property p_mon_off;
        @(posedge pclk) disable iff (!presetn)
        !cfg.en |=> !irq;
    endproperty
    a_mon_off: assert property (p_mon_off)
        else $error("disabled monitor raised an event");
    property p_mon_prio;
        @(posedge pclk) disable iff (!presetn)
        cfg.sel[3] && !result.idx[3] |=> !irq;
    endproperty
    a_mon_prio: assert property (p_mon_prio)
        else $error("priority target fired on a normal result");
    property p_mon_pulse;
        @(posedge pclk) disable iff (!presetn)
        irq |-> $past(result.valid) && $past(cfg.en);
    endproperty
    a_mon_pulse: assert property (p_mon_pulse)
        else $error("monitor event without a new result");
endmodule : amtc_monitor
`default_nettype wire

// >>> logic/amtc_pkg.sv
// Package for the converter monitor and trigger control block.
// Assumes an APB host and a converter core that posts results.
package amtc_pkg;
    // ==========================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_MON0 = 8'h00;
    localparam logic [7:0] OFS_TRIG = 8'h04;
    localparam logic [7:0] OFS_MON1 = 8'h08;
    localparam logic [7:0] OFS_PRIO = 8'h0C;
    localparam logic [7:0] OFS_CLK  = 8'h10;
    // ==========================================================
    // Field positions
    localparam int TRIG_KEY_LSB   = 0;
    localparam int TRIG_NEN_BIT   = 4;
    localparam int TRIG_NSRC_BIT  = 5;
    localparam int TRIG_PEN_BIT   = 6;
    localparam int TRIG_PSRC_BIT  = 7;
    localparam int PRIO_START_BIT = 5;
    localparam int PRIO_BUSY_BIT  = 6;
    localparam int PRIO_DONE_BIT  = 7;
    // ==========================================================
    // Reset values, key codes and result width
    localparam logic [5:0]  MON_RST    = 6'h00;
    localparam logic [3:0]  TRIG_RST   = 4'h0;
    localparam logic [15:0] CLK_RST    = 16'h0000;
    localparam logic [1:0]  KEY_FIRST  = 2'b10;
    localparam logic [1:0]  KEY_SECOND = 2'b01;
    localparam int          RES_W      = 10;
    // ==========================================================
    // Types
    typedef struct packed {
        logic       dir;
        logic [3:0] sel;
        logic       en;
    } amtc_mon_cfg_type;
    typedef struct packed {
        logic             valid;
        logic [3:0]       idx;
        logic [RES_W-1:0] data;
    } amtc_result_type;
    typedef enum logic {KEY_IDLE, KEY_ARMED} amtc_key_type;
    // Target code 1xxx means the priority result (idx bit 3)
    function automatic logic amtc_targets(logic [3:0] sel,
                                          logic [3:0] idx);
        return sel[3] ? idx[3] : (idx == {1'b0, sel[2:0]});
    endfunction : amtc_targets
endpackage : amtc_pkg

// >>> logic/amtc_prio.sv
// Top-priority conversion tracking: start pulse, busy and done flags.
// Assumes the core pulses conv_done once per started conversion.
`timescale 1ns/100ps
`default_nettype none
module amtc_prio (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic srst,
    // Requests and core answer
    input  wire logic start,
    input  wire logic conv_done,
    input  wire logic rd_clr,
    // Status and start out
    output logic      conv_start,
    output logic      busy,
    output logic      done
);
    logic busy_r, busy_nxt;
    logic done_r, done_nxt;
    logic st_r, st_nxt;
    // ==========================================================
    // Starts while busy are dropped, never queued
    always_comb begin
        st_nxt   = start && !busy_r && !srst;
        busy_nxt = busy_r;
        done_nxt = done_r;
        if (st_nxt) begin
            busy_nxt = 1'b1;
        end else if (conv_done) begin
            busy_nxt = 1'b0;
        end
        if (busy_r && conv_done) begin
            done_nxt = 1'b1;
        end else if (rd_clr) begin
            done_nxt = 1'b0;
        end
        if (srst) begin
            busy_nxt = 1'b0;
            done_nxt = 1'b0;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_r <= 1'b0;
            done_r <= 1'b0;
            st_r   <= 1'b0;
        end else begin
            busy_r <= busy_nxt;
            done_r <= done_nxt;
            st_r   <= st_nxt;
        end
    end
    assign busy       = busy_r;
    assign done       = done_r;
    assign conv_start = st_r;
    // ==========================================================
    // Checks
    property p_busy_set;
        @(posedge pclk) disable iff (!presetn)
        start && !busy && !srst |=> busy && conv_start;
    endproperty
    a_busy_set: assert property (p_busy_set)
        else $error("start did not raise busy");
    property p_done_set;
        @(posedge pclk) disable iff (!presetn)
        busy && conv_done && !srst |=> done && !busy;
    endproperty
    a_done_set: assert property (p_done_set)
        else $error("end of conversion did not set done");
endmodule : amtc_prio
`default_nettype wire

// >>> logic/amtc_top.sv
// Converter monitor and start-trigger control with APB registers.
// Assumes ext_trig and timer_match are synchronous one-cycle pulses.
`timescale 1ns/100ps
`default_nettype none
module amtc_top import amtc_pkg::*; #(
    parameter int ADDR_W    = 12,
    parameter int CLK_SET_W = 3
) (
    // Clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [ADDR_W-1:0]    paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Converter core
    input  wire amtc_result_type      result,
    input  wire logic [RES_W-1:0]     cmp0,
    input  wire logic [RES_W-1:0]     cmp1,
    input  wire logic                 prio_conv_done,
    // Hardware start sources
    input  wire logic                 ext_trig,
    input  wire logic                 timer_match,
    // Control and events out
    output logic                      norm_hw_start,
    output logic                      prio_conv_start,
    output logic                      soft_rst,
    output logic [CLK_SET_W-1:0]      conv_clk_setting,
    output logic                      mon0_irq,
    output logic                      mon1_irq,
    output logic                      prio_busy
);
    // ==========================================================
    // Elaboration checks
    if (ADDR_W < 8 || ADDR_W > 32) begin : g_addr_chk
        $error("ADDR_W must lie in 8..32");
    end
    if (CLK_SET_W < 1 || CLK_SET_W > 16) begin : g_clk_chk
        $error("CLK_SET_W must lie in 1..16");
    end

    // ==========================================================
    // State
    amtc_mon_cfg_type     mon0_r, mon0_nxt;
    amtc_mon_cfg_type     mon1_r, mon1_nxt;
    logic [7:4]           trig_r, trig_nxt;
    logic [CLK_SET_W-1:0] clk_r, clk_nxt;
    amtc_key_type         key_r, key_nxt;
    logic                 srst_r, srst_nxt;
    logic                 norm_r, norm_nxt;
    logic [31:0]          prdata_r, prdata_nxt;
    logic                 perr_r, perr_nxt;
    logic                 wr_en;
    logic                 rd_en;
    logic                 sw_start;
    logic                 prio_hw;
    logic                 norm_hw;
    logic                 ext_shared;
    logic                 prio_done;
    logic                 done_clr;
    logic [1:0]           key_in;

    // ==========================================================
    // APB access decode; zero-wait, read data captured at setup
    assign pready   = 1'b1;
    assign pslverr  = perr_r;
    assign prdata   = prdata_r;
    assign wr_en    = psel && penable && pwrite && !perr_r;
    assign rd_en    = psel && penable && !pwrite && !perr_r;
    assign key_in   = pwdata[TRIG_KEY_LSB +: 2];
    assign sw_start = wr_en && paddr == ADDR_W'(OFS_PRIO)
                      && pwdata[PRIO_START_BIT];
    // Only a done bit that was actually returned gets cleared
    assign done_clr = rd_en && paddr == ADDR_W'(OFS_PRIO)
                      && prdata_r[PRIO_DONE_BIT];

    // Read data and error for the coming access phase
    always_comb begin
        prdata_nxt = prdata_r;
        perr_nxt   = perr_r;
        if (psel && !penable) begin
            perr_nxt   = 1'b0;
            prdata_nxt = 32'h0000_0000;
            case (paddr)
                ADDR_W'(OFS_MON0): begin
                    prdata_nxt = 32'(mon0_r);
                end
                ADDR_W'(OFS_TRIG): begin
                    prdata_nxt = 32'({trig_r, 4'h0});
                end
                ADDR_W'(OFS_MON1): begin
                    prdata_nxt = 32'(mon1_r);
                end
                ADDR_W'(OFS_PRIO): begin
                    prdata_nxt[PRIO_BUSY_BIT] = prio_busy;
                    prdata_nxt[PRIO_DONE_BIT] = prio_done;
                end
                ADDR_W'(OFS_CLK): begin
                    prdata_nxt = 32'(clk_r);
                end
                default: begin
                    perr_nxt = 1'b1;
                end
            endcase
        end
    end

    // ==========================================================
    // Hardware start routing
    always_comb begin
        prio_hw = trig_r[TRIG_PSRC_BIT] ? timer_match : ext_trig;
        prio_hw = prio_hw && trig_r[TRIG_PEN_BIT];
        norm_hw = trig_r[TRIG_NSRC_BIT] ? timer_match : ext_trig;
        ext_shared = trig_r[TRIG_PEN_BIT] && !trig_r[TRIG_PSRC_BIT]
                     && !trig_r[TRIG_NSRC_BIT];
        norm_hw = norm_hw && trig_r[TRIG_NEN_BIT] && !ext_shared;
    end

    // ==========================================================
    // Register writes, key sequence and soft reset
    always_comb begin
        mon0_nxt = mon0_r;
        mon1_nxt = mon1_r;
        trig_nxt = trig_r;
        clk_nxt  = clk_r;
        key_nxt  = key_r;
        srst_nxt = 1'b0;
        norm_nxt = norm_hw && !srst_r;
        if (srst_r) begin
            mon0_nxt = amtc_mon_cfg_type'(MON_RST);
            mon1_nxt = amtc_mon_cfg_type'(MON_RST);
            trig_nxt = TRIG_RST;
            key_nxt  = KEY_IDLE;
        end else if (wr_en) begin
            case (paddr)
                ADDR_W'(OFS_MON0): begin
                    mon0_nxt = amtc_mon_cfg_type'(pwdata[5:0]);
                end
                ADDR_W'(OFS_MON1): begin
                    mon1_nxt = amtc_mon_cfg_type'(pwdata[5:0]);
                end
                ADDR_W'(OFS_CLK): begin
                    clk_nxt = pwdata[CLK_SET_W-1:0];
                end
                ADDR_W'(OFS_TRIG): begin
                    trig_nxt = pwdata[7:4];
                    case (key_r)
                        KEY_IDLE: begin
                            if (key_in == KEY_FIRST) begin
                                key_nxt = KEY_ARMED;
                            end
                        end
                        KEY_ARMED: begin
                            key_nxt  = (key_in == KEY_FIRST) ?
                                       KEY_ARMED : KEY_IDLE;
                            srst_nxt = (key_in == KEY_SECOND);
                        end
                        default: begin
                            key_nxt = KEY_IDLE;
                        end
                    endcase
                end
                default: begin
                    key_nxt = key_r;
                end
            endcase
        end
    end

    // All control state clears on the bus reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mon0_r   <= amtc_mon_cfg_type'(MON_RST);
            mon1_r   <= amtc_mon_cfg_type'(MON_RST);
            trig_r   <= TRIG_RST;
            clk_r    <= CLK_RST[CLK_SET_W-1:0];
            key_r    <= KEY_IDLE;
            srst_r   <= 1'b0;
            norm_r   <= 1'b0;
            prdata_r <= 32'h0000_0000;
            perr_r   <= 1'b0;
        end else begin
            mon0_r   <= mon0_nxt;
            mon1_r   <= mon1_nxt;
            trig_r   <= trig_nxt;
            clk_r    <= clk_nxt;
            key_r    <= key_nxt;
            srst_r   <= srst_nxt;
            norm_r   <= norm_nxt;
            prdata_r <= prdata_nxt;
            perr_r   <= perr_nxt;
        end
    end
    assign norm_hw_start    = norm_r;
    assign soft_rst         = srst_r;
    assign conv_clk_setting = clk_r;

    // ==========================================================
    // Monitors and priority tracking
    amtc_monitor u_mon0 (
        .pclk    (pclk),
        .presetn (presetn),
        .srst    (srst_r),
        .cfg     (mon0_r),
        .result  (result),
        .cmp     (cmp0),
        .irq     (mon0_irq)
    );
    amtc_monitor u_mon1 (
        .pclk    (pclk),
        .presetn (presetn),
        .srst    (srst_r),
        .cfg     (mon1_r),
        .result  (result),
        .cmp     (cmp1),
        .irq     (mon1_irq)
    );
    amtc_prio u_prio (
        .pclk       (pclk),
        .presetn    (presetn),
        .srst       (srst_r),
        .start      (prio_hw || sw_start),
        .conv_done  (prio_conv_done),
        .rd_clr     (done_clr),
        .conv_start (prio_conv_start),
        .busy       (prio_busy),
        .done       (prio_done)
    );

    // ==========================================================
    // Checks
    property p_key_pair;
        @(posedge pclk) disable iff (!presetn)
        wr_en && paddr == ADDR_W'(OFS_TRIG) && key_r == KEY_ARMED
        && key_in == KEY_SECOND && !srst_r |=> soft_rst;
    endproperty
    a_key_pair: assert property (p_key_pair)
        else $error("key pair did not reset");
    property p_key_only;
        @(posedge pclk) disable iff (!presetn)
        soft_rst |-> $past(key_r) == KEY_ARMED && $past(wr_en);
    endproperty
    a_key_only: assert property (p_key_only)
        else $error("soft reset without the key pair");
    property p_srst_keep;
        @(posedge pclk) disable iff (!presetn)
        soft_rst |=> mon0_r == MON_RST && trig_r == TRIG_RST
        && conv_clk_setting == $past(conv_clk_setting);
    endproperty
    a_srst_keep: assert property (p_srst_keep)
        else $error("soft reset cleared wrong state");
    property p_norm_timer;
        @(posedge pclk) disable iff (!presetn)
        trig_r[TRIG_NEN_BIT] && trig_r[TRIG_NSRC_BIT] && timer_match
        && !soft_rst |=> norm_hw_start;
    endproperty
    a_norm_timer: assert property (p_norm_timer)
        else $error("timer match did not start normal conversion");
    property p_norm_off;
        @(posedge pclk) disable iff (!presetn)
        !trig_r[TRIG_NEN_BIT] |=> !norm_hw_start;
    endproperty
    a_norm_off: assert property (p_norm_off)
        else $error("normal start while hardware start disabled");
    property p_prio_ext;
        @(posedge pclk) disable iff (!presetn)
        trig_r[TRIG_PEN_BIT] && !trig_r[TRIG_PSRC_BIT] && ext_trig
        && !prio_busy && !soft_rst |=> prio_conv_start;
    endproperty
    a_prio_ext: assert property (p_prio_ext)
        else $error("external trigger did not start priority");
    property p_prio_off;
        @(posedge pclk) disable iff (!presetn)
        !trig_r[TRIG_PEN_BIT] && !sw_start |=> !prio_conv_start;
    endproperty
    a_prio_off: assert property (p_prio_off)
        else $error("priority start while hardware start disabled");
endmodule : amtc_top
`default_nettype wire

// >>> testbench/tb.sv
// Self-checking bench for the monitor and start control block.
// Drives APB, result posts and start pulses itself; no partner model.
`timescale 1ns/100ps
`default_nettype none
module tb import amtc_pkg::*;;
    // ==========================================================
    // Signals
    logic             pclk = 1'b0;
    logic             presetn = 1'b0;
    logic             psel = 1'b0;
    logic             penable = 1'b0;
    logic             pwrite = 1'b0;
    logic [11:0]      paddr = 12'h000;
    logic [31:0]      pwdata = 32'h0000_0000;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    amtc_result_type  result = '0;
    logic [RES_W-1:0] cmp0 = 10'h100;
    logic [RES_W-1:0] cmp1 = 10'h200;
    logic             prio_conv_done = 1'b0;
    logic             ext_trig = 1'b0;
    logic             timer_match = 1'b0;
    logic             norm_hw_start;
    logic             prio_conv_start;
    logic             soft_rst;
    logic [2:0]       conv_clk_setting;
    logic             mon0_irq;
    logic             mon1_irq;
    logic             prio_busy;
    int               err_total = 0;
    int               samples_checked = 0;
    int               cyc = 0;
    logic [31:0]      q;
    logic             e;

    // ==========================================================
    // Design and clock
    amtc_top #(.ADDR_W(12), .CLK_SET_W(3)) dut_u (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .result, .cmp0, .cmp1,
        .prio_conv_done, .ext_trig, .timer_match, .norm_hw_start,
        .prio_conv_start, .soft_rst, .conv_clk_setting, .mon0_irq,
        .mon1_irq, .prio_busy
    );
    always #20 pclk = ~pclk;

    // Hang guard, far above the roughly 1100 cycles the run needs
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            finish_test();
        end
    end

    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s seen %h expected %h",
                     $time, what, seen, exp);
        end
    endtask : chk

    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(q, exp, "register read");
    endtask : rd

    // One-cycle start or done pulses; ends just after the answer edge
    task automatic pulse(input logic x, input logic t, input logic d);
        @(posedge pclk);
        ext_trig       <= x;
        timer_match    <= t;
        prio_conv_done <= d;
        @(posedge pclk);
        ext_trig       <= 1'b0;
        timer_match    <= 1'b0;
        prio_conv_done <= 1'b0;
        #1;
    endtask : pulse

    // Post one result and judge both monitor events a cycle later
    task automatic mon_hit(input logic m, input logic [3:0] idx,
                           input logic [9:0] d, input logic exp);
        @(posedge pclk);
        result <= '{1'b1, idx, d};
        @(posedge pclk);
        result.valid <= 1'b0;
        #1;
        chk(32'(m ? mon1_irq : mon0_irq), 32'(exp), "monitor event");
        chk(32'(m ? mon0_irq : mon1_irq), 32'h0, "other monitor");
    endtask : mon_hit

    // ==========================================================
    // Scenarios
    task automatic t_map;
        for (int k = 0; k < 5; k++) begin
            rd(12'(4 * k), 32'h0000_0000);
            chk(32'(e), 32'h0, "mapped error");
        end
        apb(1'b1, 12'h014, 32'hFFFF_FFFF);
        chk(32'(e), 32'h1, "unmapped write");
        // Refused write must leave monitor 0 and starts off
        rd(12'h000, 32'h0000_0000);
        rd(12'h004, 32'h0000_0000);
        apb(1'b0, 12'h002, 32'h0000_0000);
        chk(32'(e), 32'h1, "unaligned read");
    endtask : t_map

    task automatic t_monitor(input logic m);
        logic [11:0] a;
        logic [9:0]  lim;
        a   = m ? 12'h008 : 12'h000;
        lim = m ? cmp1 : cmp0;
        apb(1'b1, a, 32'h0000_0000);
        mon_hit(m, 4'h0, 10'h000, 1'b0);
        apb(1'b1, a, 32'h0000_0001);
        mon_hit(m, 4'h0, lim - 10'h001, 1'b1);
        mon_hit(m, 4'h0, lim, 1'b0);
        apb(1'b1, a, 32'h0000_0021);
        mon_hit(m, 4'h0, lim + 10'h001, 1'b1);
        mon_hit(m, 4'h0, lim - 10'h001, 1'b0);
        // Every target code against every result slot
        for (int s = 0; s < 16; s++) begin
            apb(1'b1, a, {26'h0, 1'b0, 4'(s), 1'b1});
            rd(a, {26'h0, 1'b0, 4'(s), 1'b1});
            for (int i = 0; i < 9; i++) begin
                mon_hit(m, (i == 8) ? {1'b1, 3'(s)} : 4'(i), 10'h000,
                        (s > 7) ? (i == 8) : (i == s));
            end
        end
        apb(1'b1, a, 32'h0000_0000);
    endtask : t_monitor

    task automatic t_starts;
        logic xn;
        logic xp;
        for (int c = 0; c < 16; c++) begin
            if (c[2] && !c[3] && !c[1]) continue;
            apb(1'b1, 12'h004, {24'h0, 4'(c), 4'h3});
            rd(12'h004, {24'h0, 4'(c), 4'h0});
            for (int s = 0; s < 2; s++) begin
                pulse(s == 0, s == 1, 1'b0);
                xn = c[0] && (c[1] == s[0]);
                xp = c[2] && (c[3] == s[0]);
                chk(32'(norm_hw_start), 32'(xn), "normal start");
                chk(32'(prio_conv_start), 32'(xp), "prio start");
                if (xp) begin
                    pulse(1'b0, 1'b0, 1'b1);
                    rd(12'h00C, 32'h0000_0080);
                end
            end
        end
        apb(1'b1, 12'h004, 32'h0000_0000);
    endtask : t_starts

    task automatic t_prio;
        int n;
        apb(1'b1, 12'h004, 32'h0000_0040);
        pulse(1'b1, 1'b0, 1'b0);
        chk(32'(prio_busy), 32'h1, "busy after start");
        pulse(1'b1, 1'b0, 1'b0);
        chk(32'(prio_conv_start), 32'h0, "start while busy");
        rd(12'h00C, 32'h0000_0040);
        pulse(1'b0, 1'b0, 1'b1);
        chk(32'(prio_busy), 32'h0, "busy after done");
        rd(12'h00C, 32'h0000_0080);
        rd(12'h00C, 32'h0000_0000);
        // Software start; answer awaited under a small bound
        apb(1'b1, 12'h00C, 32'h0000_0020);
        n = 0;
        #1;
        while (prio_conv_start !== 1'b1 && n < 4) begin
            @(posedge pclk);
            #1;
            n++;
        end
        chk(32'(prio_busy), 32'h1, "busy after soft start");
        pulse(1'b0, 1'b0, 1'b1);
        rd(12'h00C, 32'h0000_0080);
        apb(1'b1, 12'h004, 32'h0000_0000);
    endtask : t_prio

    task automatic t_srst;
        apb(1'b1, 12'h010, 32'h0000_0005);
        // Busy priority conversion that the soft reset must drop
        apb(1'b1, 12'h00C, 32'h0000_0020);
        apb(1'b1, 12'h000, 32'h0000_0021);
        // Priority on the timer keeps the trigger free for normal
        apb(1'b1, 12'h004, 32'h0000_00D2);
        apb(1'b1, 12'h004, 32'h0000_00D0);
        apb(1'b1, 12'h004, 32'h0000_00D1);
        #1;
        chk(32'(soft_rst), 32'h0, "key broken");
        chk(32'(prio_busy), 32'h1, "busy before reset");
        apb(1'b1, 12'h004, 32'h0000_00D2);
        apb(1'b1, 12'h008, 32'h0000_003F);
        apb(1'b1, 12'h004, 32'h0000_00D1);
        #1;
        chk(32'(soft_rst), 32'h1, "key pair fires");
        @(posedge pclk);
        #1;
        chk(32'(soft_rst), 32'h0, "reset pulse width");
        rd(12'h000, 32'h0000_0000);
        rd(12'h004, 32'h0000_0000);
        rd(12'h008, 32'h0000_0000);
        rd(12'h010, 32'h0000_0005);
        rd(12'h00C, 32'h0000_0000);
        chk(32'(prio_busy), 32'h0, "busy cleared");
        chk(32'(conv_clk_setting), 32'h5, "clock setting kept");
    endtask : t_srst

    // ==========================================================
    // Sequence and verdict
    task automatic finish_test;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_map();
        t_monitor(1'b0);
        t_monitor(1'b1);
        t_starts();
        t_prio();
        t_srst();
        repeat (2) @(posedge pclk);
        finish_test();
    end
endmodule : tb
`default_nettype wire
